// ### verilog/ssr_pkg.sv
`default_nettype none
package ssr_pkg;

  // ----------------------------------------------------------------
  // Register map (index = printed offset, byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [7:0] SSR_IDX_CTL = 8'hC0;
  localparam logic [7:0] SSR_IDX_RATE = 8'hCF;
  localparam logic [7:0] SSR_IDX_IRQ_STS = 8'hD0;
  localparam logic [7:0] SSR_IDX_IRQ_MSK = 8'hD1;
  localparam logic [9:0] SSR_ADDR_CTL = {SSR_IDX_CTL, 2'b00};
  localparam logic [9:0] SSR_ADDR_RATE = {SSR_IDX_RATE, 2'b00};
  localparam logic [9:0] SSR_ADDR_IRQ_STS = {SSR_IDX_IRQ_STS, 2'b00};
  localparam logic [9:0] SSR_ADDR_IRQ_MSK = {SSR_IDX_IRQ_MSK, 2'b00};

  localparam logic [7:0] SSR_CTL_RESET = 8'h00;
  localparam logic [7:0] SSR_RATE_RESET = 8'h00;
  localparam logic [2:0] SSR_IRQ_RESET = 3'h0;

  // Interrupt status bit positions
  localparam int SSR_IRQ_SI = 0;
  localparam int SSR_IRQ_BUS_FREE = 1;
  localparam int SSR_IRQ_SCL_LOW = 2;

  localparam logic [7:0] SSR_IDLE_CODE = 8'hF8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SSR_CLK_PERIOD_PS = 4000;
  localparam int SSR_HIGH_EXTRA_NS = 625;
  localparam int SSR_HIGH_EXTRA_CYC =
    (SSR_HIGH_EXTRA_NS * 1000 + SSR_CLK_PERIOD_PS - 1) / SSR_CLK_PERIOD_PS;
  localparam logic [8:0] SSR_BFT_BASE = 9'h101;
  localparam logic [3:0] SSR_BFT_MULT = 4'hA;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic busy;
    logic enable;
    logic start_req;
    logic stop_req;
    logic serial_event;
    logic ack_assert;
    logic bus_free_timeout_enable;
    logic scl_low_timeout_enable;
  } ssr_ctl_t;

  typedef struct packed {
    logic o;
    logic oe_n;
  } ssr_pin_drv_t;

endpackage : ssr_pkg
`default_nettype wire

// ### verilog/ssr_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module ssr_pin_sync
  import ssr_pkg::*;
(
  input wire logic hclk,     // System clock
  input wire logic hresetn,  // Async reset, active low
  input wire logic pin_i,    // Raw pin level
  output logic level_o       // Filtered level
);

  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic level_q;
  logic level_d;

  // Change accepted once second and third stages agree
  always_comb
  begin
    sync_d = {sync_q[1:0], pin_i};
    level_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : level_q;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_q <= 3'h7;
      level_q <= 1'b1;
    end
    else
    begin
      sync_q <= sync_d;
      level_q <= level_d;
    end
  end

  assign level_o = level_q;

endmodule : ssr_pin_sync
`default_nettype wire

// ### verilog/ssr_top.sv
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module ssr_top
  import ssr_pkg::*;
(
  input wire logic hclk,             // System clock
  input wire logic hresetn,          // Async reset, active low
  input wire logic hsel,             // AHB select
  input wire logic [31:0] haddr,     // AHB address
  input wire logic [1:0] htrans,     // AHB transfer type
  input wire logic hwrite,           // AHB write
  input wire logic [2:0] hsize,      // AHB size
  input wire logic [31:0] hwdata,    // AHB write data
  input wire logic hready,           // AHB ready in
  output logic [31:0] hrdata,        // AHB read data
  output logic hreadyout,            // AHB ready out
  output logic hresp,                // AHB response
  input wire logic scl_i,            // SCL pin level
  output logic scl_o,                // SCL drive value
  output logic scl_oe_n,             // SCL enable, low drives
  input wire logic sda_i,            // SDA pin level
  output logic sda_o,                // SDA drive value
  output logic sda_oe_n,             // SDA enable, low drives
  input wire logic master_mode,      // Protocol engine is master
  input wire logic bus_busy,         // Protocol busy status
  input wire logic state_enter,      // Pulse, new protocol state
  input wire logic [7:0] state_code, // Code of entered state
  input wire logic stop_seen,        // Pulse, STOP detected
  input wire logic ack_cycle,        // In acknowledge clock cycle
  input wire logic addressed,        // Device was addressed
  input wire logic aux_timer_en,     // Auxiliary timer enabled
  input wire logic aux_timer_ovf,    // Pulse, auxiliary overflow
  output logic aux_timer_count,      // Auxiliary timer count enable
  output logic bus_free,             // Pulse, bus-free timeout
  output logic start_issue,          // Pulse, issue pending start
  output logic [7:0] ctl_out,        // Control flags
  output logic irq                   // Interrupt, active high
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic scl_f;
  logic sda_f;

  ssr_pin_sync u_scl_sync (.hclk(hclk), .hresetn(hresetn), .pin_i(scl_i), .level_o(scl_f));
  ssr_pin_sync u_sda_sync (.hclk(hclk), .hresetn(hresetn), .pin_i(sda_i), .level_o(sda_f));

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  ssr_ctl_t ctl_q;
  ssr_ctl_t ctl_d;
  logic [7:0] rate_q;
  logic [7:0] rate_d;
  logic [2:0] sts_q;
  logic [2:0] sts_d;
  logic [2:0] msk_q;
  logic [2:0] msk_d;
  logic wr_q;
  logic wr_d;
  logic [9:0] wa_q;
  logic [9:0] wa_d;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic [2:0] ev_set;
  logic addr_ph;
  logic wr_ctl;

  assign addr_ph = hsel & hready & htrans[1];
  assign wr_ctl = wr_q & (wa_q == SSR_ADDR_CTL);

  always_comb
  begin
    wr_d = addr_ph & hwrite;
    wa_d = addr_ph ? haddr[9:0] : wa_q;
    rd_d = rd_q;
    if (addr_ph & !hwrite)
    begin
      case (haddr[9:0])
        SSR_ADDR_CTL: rd_d = {24'h000000, ctl_d};
        SSR_ADDR_RATE: rd_d = {24'h000000, rate_d};
        SSR_ADDR_IRQ_STS: rd_d = {29'h00000000, sts_d};
        SSR_ADDR_IRQ_MSK: rd_d = {29'h00000000, msk_d};
        default: rd_d = 32'h00000000;
      endcase
    end
  end

  // Control flags: the event flag set wins over a software clear
  always_comb
  begin
    ctl_d = ctl_q;
    rate_d = rate_q;
    msk_d = msk_q;
    if (wr_ctl)
      ctl_d = ssr_ctl_t'(hwdata[7:0]);
    if (wr_q & (wa_q == SSR_ADDR_RATE))
      rate_d = hwdata[7:0];
    if (wr_q & (wa_q == SSR_ADDR_IRQ_MSK))
      msk_d = hwdata[2:0];
    ctl_d.busy = bus_busy;
    if (stop_seen)
      ctl_d.stop_req = 1'b0;
    if (state_enter & (state_code != SSR_IDLE_CODE))
      ctl_d.serial_event = 1'b1;
    if (start_issue)
      ctl_d.start_req = 1'b0;
  end

  always_comb
  begin
    sts_d = sts_q;
    if (wr_q & (wa_q == SSR_ADDR_IRQ_STS))
      sts_d = sts_q & ~hwdata[2:0];
    sts_d = sts_d | ev_set;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctl_q <= ssr_ctl_t'(SSR_CTL_RESET);
      rate_q <= SSR_RATE_RESET;
      sts_q <= SSR_IRQ_RESET;
      msk_q <= SSR_IRQ_RESET;
      wr_q <= 1'b0;
      wa_q <= 10'h000;
      rd_q <= 32'h00000000;
    end
    else
    begin
      ctl_q <= ctl_d;
      rate_q <= rate_d;
      sts_q <= sts_d;
      msk_q <= msk_d;
      wr_q <= wr_d;
      wa_q <= wa_d;
      rd_q <= rd_d;
    end
  end

  assign hrdata = rd_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ctl_out = ctl_q;
  assign irq = |(sts_q & msk_q);

  // ----------------------------------------------------------------
  // SCL rate timer
  // ----------------------------------------------------------------
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] hold_q;
  logic [7:0] hold_d;
  logic low_q;
  logic low_d;
  logic gen_on;
  logic cnt_run;

  assign gen_on = ctl_q.enable & master_mode;
  // High phase waits for the line to be seen high, then the fixed extra
  assign cnt_run = low_q | (scl_f & (hold_q == 8'(SSR_HIGH_EXTRA_CYC)));

  always_comb
  begin
    cnt_d = cnt_q;
    low_d = low_q;
    hold_d = hold_q;
    if (!gen_on)
    begin
      cnt_d = rate_q;
      low_d = 1'b0;
      hold_d = 8'h00;
    end
    else if (ctl_q.serial_event & low_q)
      cnt_d = cnt_q;
    else if (cnt_run)
    begin
      if (cnt_q == 8'hFF)
      begin
        cnt_d = rate_q;
        low_d = !low_q;
        hold_d = 8'h00;
      end
      else
        cnt_d = cnt_q + 8'h01;
    end
    else if (!low_q & scl_f)
      hold_d = hold_q + 8'h01;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_q <= SSR_RATE_RESET;
      low_q <= 1'b0;
      hold_q <= 8'h00;
    end
    else
    begin
      cnt_q <= cnt_d;
      low_q <= low_d;
      hold_q <= hold_d;
    end
  end

  // Event flag stretches the clock low in any mode while enabled
  assign scl_o = 1'b0;
  assign scl_oe_n = !((gen_on & low_q) | (ctl_q.enable & ctl_q.serial_event & !scl_f));

  // ----------------------------------------------------------------
  // Acknowledge drive
  // ----------------------------------------------------------------
  assign sda_o = 1'b0;
  assign sda_oe_n = !(ctl_q.enable & ack_cycle & ctl_q.ack_assert & addressed);

  // ----------------------------------------------------------------
  // Bus-free timeout and SCL-low timeout
  // ----------------------------------------------------------------
  logic [11:0] bft_q;
  logic [11:0] bft_d;
  logic [11:0] bft_lim;
  logic bf_hit;

  assign bft_lim = (12'(SSR_BFT_BASE) - 12'(rate_q)) * 12'(SSR_BFT_MULT);
  assign bf_hit = ctl_q.bus_free_timeout_enable & scl_f & sda_f & (bft_q == bft_lim - 12'h001);

  always_comb
  begin
    bft_d = bft_q;
    if (!(ctl_q.bus_free_timeout_enable & scl_f & sda_f))
      bft_d = 12'h000;
    else if (bft_q < bft_lim)
      bft_d = bft_q + 12'h001;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      bft_q <= 12'h000;
    else
      bft_q <= bft_d;
  end

  assign bus_free = bf_hit;
  assign start_issue = bf_hit & ctl_q.start_req & ctl_q.enable;
  assign aux_timer_count = ctl_q.scl_low_timeout_enable & aux_timer_en & !scl_f;

  always_comb
  begin
    ev_set = 3'h0;
    ev_set[SSR_IRQ_SI] = state_enter & (state_code != SSR_IDLE_CODE);
    ev_set[SSR_IRQ_BUS_FREE] = bf_hit;
    ev_set[SSR_IRQ_SCL_LOW] = aux_timer_ovf & ctl_q.scl_low_timeout_enable;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_stretch_low: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctl_q.enable & ctl_q.serial_event & low_q & gen_on) |-> !scl_oe_n)
    else $error("SCL released while event flag set");
  chk_si_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctl_q.serial_event & !wr_ctl) |=> ctl_q.serial_event)
    else $error("Event flag cleared without software");
  chk_ack_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctl_q.enable & ack_cycle & addressed) |-> (sda_oe_n == !ctl_q.ack_assert))
    else $error("Acknowledge level wrong");
  chk_wrap_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
    (gen_on & cnt_run & !(ctl_q.serial_event & low_q) & cnt_q == 8'hFF)
    |=> (low_q != $past(low_q)) && (cnt_q == $past(rate_q)))
    else $error("Counter wrap did not toggle and reload");
  chk_low_count: assert property (@(posedge hclk) disable iff (!hresetn)
    (gen_on & !ctl_q.serial_event & low_q & cnt_q != 8'hFF & $stable(rate_q))
    |=> (cnt_q == $past(cnt_q) + 8'h01) && low_q)
    else $error("Low phase counter not counting");
  chk_idle_code: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_enter & state_code == SSR_IDLE_CODE & !ctl_q.serial_event & !wr_ctl)
    |=> !ctl_q.serial_event)
    else $error("Idle code set event flag");
  chk_bus_free: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_free |-> ($past(scl_f, 2) & $past(sda_f, 2) & ctl_q.bus_free_timeout_enable))
    else $error("Bus free without idle lines");
  chk_start_pend: assert property (@(posedge hclk) disable iff (!hresetn)
    start_issue |=> !ctl_q.start_req)
    else $error("Pending start not consumed");
  chk_low_timeout: assert property (@(posedge hclk) disable iff (!hresetn)
    (aux_timer_ovf & ctl_q.scl_low_timeout_enable) |=> sts_q[SSR_IRQ_SCL_LOW])
    else $error("SCL-low timeout not flagged");
  chk_free_limit: assert property (@(posedge hclk) disable iff (!hresetn)
    bf_hit |-> (bft_q == 12'(int'(SSR_BFT_MULT) * (int'(SSR_BFT_BASE) - int'(rate_q)) - 1)))
    else $error("Bus-free period wrong");

endmodule : ssr_top
`default_nettype wire

// ### testbench/ssr_bus_peer.sv
`timescale 1ns/1ns
`default_nettype none
module ssr_bus_peer (
  input wire logic scl_o,     // Design SCL value
  input wire logic scl_oe_n,  // Design SCL enable
  input wire logic sda_o,     // Design SDA value
  input wire logic sda_oe_n,  // Design SDA enable
  input wire logic hold_scl,  // Peer stretches SCL
  output logic scl_line,      // Resolved SCL
  output logic sda_line       // Resolved SDA
);
  // Open-drain lines with pull-ups
  assign scl_line = !((!scl_oe_n && !scl_o) || hold_scl);
  assign sda_line = !(!sda_oe_n && !sda_o);
endmodule : ssr_bus_peer
`default_nettype wire

// ### testbench/ssr_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module ssr_top_bench;
  import ssr_pkg::*;
  localparam logic [7:0] PRESET = 8'hF0;
  localparam int LOW_CYC = 256 - int'(PRESET);
  localparam int HI_MIN = SSR_HIGH_EXTRA_CYC + LOW_CYC + 1;
  localparam int HI_MAX = HI_MIN + 6;
  localparam int BFT = 10 * (LOW_CYC + 1);
  logic hclk, hresetn, hwrite, master_mode, state_enter, ack_cycle, addressed;
  logic aux_timer_en, aux_timer_ovf, hold_scl, hreadyout, hresp, scl_o, scl_oe_n;
  logic sda_o, sda_oe_n, scl_line, sda_line, aux_timer_count, bus_free;
  logic start_issue, irq;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0] state_code, ctl_out;
  int error_cnt, num_checks, cyc;

  ssr_top i_ssr_top (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl_line),
    .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .master_mode(master_mode), .bus_busy(1'h0),
    .state_enter(state_enter), .state_code(state_code), .stop_seen(1'h0),
    .ack_cycle(ack_cycle), .addressed(addressed), .aux_timer_en(aux_timer_en),
    .aux_timer_ovf(aux_timer_ovf), .aux_timer_count(aux_timer_count),
    .bus_free(bus_free), .start_issue(start_issue), .ctl_out(ctl_out), .irq(irq));

  ssr_bus_peer i_ssr_bus_peer (.scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .hold_scl(hold_scl), .scl_line(scl_line), .sda_line(sda_line));

  initial
  begin
    hclk = 1'h0;
    forever #2 hclk = ~hclk;
  end

  task automatic end_of_test();
    if (error_cnt == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {22'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'h1, a, d, r);
  endtask : wr

  task automatic rd(input string nm, input logic [9:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'h0, a, 32'h0, r);
    chk(nm, e, r);
    chk("hresp", 32'h0, hresp);
  endtask : rd

  task automatic pulse(input logic [7:0] code);
    @(posedge hclk);
    state_code <= code;
    state_enter <= 1'h1;
    @(posedge hclk);
    state_enter <= 1'h0;
    repeat (2) @(negedge hclk);
  endtask : pulse

  // Counts negedge samples while scl_oe_n stays at lvl
  task automatic phase(input logic lvl, output int n);
    n = 0;
    while (scl_oe_n === lvl && n < 2000)
    begin
      n++;
      @(negedge hclk);
    end
  endtask : phase

  task automatic t_regs();
    rd("ctl_rst", SSR_ADDR_CTL, 32'h0);
    rd("rate_rst", SSR_ADDR_RATE, 32'h0);
    rd("sts_rst", SSR_ADDR_IRQ_STS, 32'h0);
    rd("msk_rst", SSR_ADDR_IRQ_MSK, 32'h0);
    wr(SSR_ADDR_RATE, {24'h0, PRESET});
    rd("rate", SSR_ADDR_RATE, {24'h0, PRESET});
    wr(10'h3FC, 32'hFF);
    rd("unmapped", 10'h3FC, 32'h0);
    wr(SSR_ADDR_CTL, 32'h80);
    rd("busy_ro", SSR_ADDR_CTL, 32'h0);
  endtask : t_regs

  task automatic t_event();
    wr(SSR_ADDR_IRQ_MSK, 32'h7);
    pulse(8'hF8);
    chk("idle_flag", 32'h0, ctl_out[3]);
    chk("idle_irq", 32'h0, irq);
    pulse(8'h08);
    chk("flag_set", 32'h1, ctl_out[3]);
    chk("irq_on", 32'h1, irq);
    wr(SSR_ADDR_IRQ_MSK, 32'h6);
    @(negedge hclk);
    chk("irq_masked", 32'h0, irq);
    wr(SSR_ADDR_IRQ_MSK, 32'h7);
    wr(SSR_ADDR_CTL, 32'h0);
    @(negedge hclk);
    chk("flag_clr", 32'h0, ctl_out[3]);
    wr(SSR_ADDR_IRQ_STS, 32'h1);
    rd("sts_w1c", SSR_ADDR_IRQ_STS, 32'h0);
    chk("irq_off", 32'h0, irq);
  endtask : t_event

  task automatic t_ack();
    wr(SSR_ADDR_CTL, 32'h44);
    @(posedge hclk);
    ack_cycle <= 1'h1;
    addressed <= 1'h1;
    repeat (2) @(negedge hclk);
    chk("ack_low", 32'h0, sda_oe_n);
    chk("ack_line", 32'h0, sda_line);
    chk("sda_val", 32'h0, sda_o);
    @(posedge hclk);
    addressed <= 1'h0;
    repeat (2) @(negedge hclk);
    chk("ack_unaddr", 32'h1, sda_oe_n);
    @(posedge hclk);
    addressed <= 1'h1;
    wr(SSR_ADDR_CTL, 32'h40);
    @(negedge hclk);
    chk("nack", 32'h1, sda_oe_n);
    @(posedge hclk);
    ack_cycle <= 1'h0;
  endtask : t_ack

  task automatic t_aux();
    wr(SSR_ADDR_CTL, 32'h41);
    @(posedge hclk);
    aux_timer_en <= 1'h1;
    hold_scl <= 1'h1;
    repeat (6) @(negedge hclk);
    chk("aux_count", 32'h1, aux_timer_count);
    @(posedge hclk);
    hold_scl <= 1'h0;
    repeat (6) @(negedge hclk);
    chk("aux_stop", 32'h0, aux_timer_count);
    @(posedge hclk);
    aux_timer_ovf <= 1'h1;
    @(posedge hclk);
    aux_timer_ovf <= 1'h0;
    rd("aux_sts", SSR_ADDR_IRQ_STS, 32'h4);
    wr(SSR_ADDR_IRQ_STS, 32'h4);
    wr(SSR_ADDR_CTL, 32'h0);
  endtask : t_aux

  task automatic t_free();
    int n;
    wr(SSR_ADDR_CTL, 32'h62);
    n = 0;
    do
    begin
      @(negedge hclk);
      n++;
    end
    while (bus_free !== 1'h1 && n < 3000);
    chk("bft_period", 32'h1, n >= BFT - 2 && n <= BFT + 2);
    chk("start_issue", 32'h1, start_issue);
    repeat (2) @(negedge hclk);
    chk("start_clr", 32'h0, ctl_out[5]);
    rd("bft_sts", SSR_ADDR_IRQ_STS, 32'h2);
    wr(SSR_ADDR_IRQ_STS, 32'h2);
    wr(SSR_ADDR_CTL, 32'h0);
  endtask : t_free

  // Peer clocks SCL at 68 ns as master (8 cycles low, 9 high); the flag stretches its low half
  task automatic t_slave();
    wr(SSR_ADDR_CTL, 32'h40);
    repeat (2)
    begin
      @(posedge hclk);
      hold_scl <= 1'h1;
      repeat (8) @(posedge hclk);
      hold_scl <= 1'h0;
      repeat (8) @(posedge hclk);
    end
    @(negedge hclk);
    chk("slave_free", 32'h1, scl_line);
    pulse(8'h60);
    chk("slave_wait", 32'h1, scl_oe_n);
    @(posedge hclk);
    hold_scl <= 1'h1;
    repeat (8) @(posedge hclk);
    hold_scl <= 1'h0;
    repeat (8) @(negedge hclk);
    chk("slave_held", 32'h0, scl_oe_n);
    chk("slave_line", 32'h0, scl_line);
    chk("scl_val", 32'h0, scl_o);
    wr(SSR_ADDR_CTL, 32'h40);
    @(negedge hclk);
    chk("slave_rel", 32'h1, scl_line);
    wr(SSR_ADDR_CTL, 32'h0);
  endtask : t_slave

  task automatic t_scl();
    int lo;
    int hi;
    wr(SSR_ADDR_CTL, 32'h40);
    @(posedge hclk);
    master_mode <= 1'h1;
    @(negedge hclk);
    phase(1'h1, hi);
    phase(1'h0, lo);
    chk("scl_low", LOW_CYC, lo);
    phase(1'h1, hi);
    chk("scl_high", 32'h1, hi >= HI_MIN && hi <= HI_MAX);
    @(posedge hclk);
    hold_scl <= 1'h1;
    repeat (LOW_CYC + 40) @(posedge hclk);
    hold_scl <= 1'h0;
    @(negedge hclk);
    phase(1'h1, hi);
    chk("scl_stretch", 32'h1, hi >= HI_MIN && hi <= HI_MAX);
    pulse(8'h10);
    repeat (100) @(negedge hclk);
    chk("scl_held", 32'h0, scl_oe_n);
    chk("flag_kept", 32'h1, ctl_out[3]);
    wr(SSR_ADDR_CTL, 32'h40);
    @(negedge hclk);
    phase(1'h0, lo);
    chk("scl_resume", 32'h1, lo <= LOW_CYC + 1);
    @(posedge hclk);
    master_mode <= 1'h0;
    wr(SSR_ADDR_CTL, 32'h0);
  endtask : t_scl

  initial
  begin
    hresetn = 1'h0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
    state_enter = 1'h0;
    state_code = 8'h0;
    ack_cycle = 1'h0;
    addressed = 1'h0;
    aux_timer_en = 1'h0;
    aux_timer_ovf = 1'h0;
    master_mode = 1'h0;
    hold_scl = 1'h0;
    error_cnt = 0;
    num_checks = 0;
    cyc = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    t_regs();
    t_event();
    t_ack();
    t_aux();
    t_free();
    t_slave();
    t_scl();
    end_of_test();
  end
endmodule : ssr_top_bench
`default_nettype wire
